/* File: shared/regport_pkg.sv */
// Package with constants shared by both ends of the register access port.
// How it works
// - Control bit 7 enables register access mode
// - Control bit 6: one writes, zero reads
// - Six low control bits hold register number
// - Read acknowledge echoes control byte unchanged
// - Write acknowledge echoes control with bit6 cleared
// - Read returns selected register in input word
// - Words travel high byte first, low second
// - Host ignores input word after write
// - Device ignores output word during reads
// - Protected registers reject writes except register 31
// - Key 0x1235 in register 31 unlocks writes
// - Any other value relocks user registers
// - Changed values apply only after power cycle; here page select and key act at once, and reset clears all registers but page select, which loads four
// - Sixty-four words; upper half paged by register 4
// - Each page gives thirty-two words
// - Pages 4-7 channels, 8 command, 9 acyclic
// - Host selects page before paged access
package regport_pkg;
  localparam int unsigned CTRL_ACCESS_BIT = 7;
  localparam int unsigned CTRL_WRITE_BIT = 6;
  localparam int unsigned REG_NUM_W = 6;
  localparam int unsigned NUM_REGS = 64;
  localparam int unsigned PAGE_WORDS = 32;
  localparam int unsigned FIRST_PAGE = 4;
  localparam int unsigned NUM_PAGES = 6;
  localparam logic [5:0] PAGE_SELECT_OFS = 6'h04;
  localparam logic [5:0] WRITE_UNLOCK_KEY_OFS = 6'h1F;
  localparam logic [5:0] PAGED_BASE_OFS = 6'h20;
  localparam logic [15:0] UNLOCK_KEY = 16'h1235;
  localparam logic [15:0] PAGE_SELECT_RST = 16'h0004;
  localparam logic [15:0] WRITE_UNLOCK_KEY_RST = 16'h0000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Host waits one cycle more than this for the acknowledge (256 cycles) before giving up.
  localparam logic [7:0] HOST_TIMEOUT_CYC = 8'hFF;
endpackage : regport_pkg

/* File: shared/regport_if.sv */
// Interface carrying the three-byte process image between host and terminal.
`timescale 1ns/1ps
interface regport_if;
  logic [7:0] out_byte0;
  logic [7:0] out_byte1;
  logic [7:0] out_byte2;
  logic [7:0] in_byte0;
  logic [7:0] in_byte1;
  logic [7:0] in_byte2;
  modport device (input out_byte0, input out_byte1, input out_byte2,
                  output in_byte0, output in_byte1, output in_byte2);
  modport host (output out_byte0, output out_byte1, output out_byte2,
                input in_byte0, input in_byte1, input in_byte2);
endinterface : regport_if

/* File: logic/regport_device.sv */
// Terminal end: paged register file answering control bytes from the process image.
`timescale 1ns/1ps
module regport_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Process image link.
  regport_if.device link,
  // Cyclic process data when register access is off.
  output logic [15:0] proc_out_word,
  input wire logic [15:0] proc_in_word,
  // Terminal state.
  output logic unlocked,
  output logic [15:0] active_page
);
  import regport_pkg::*;

  typedef struct packed {
    logic [NUM_REGS/2-1:0][15:0] fixed_regs;
    logic [NUM_PAGES-1:0][PAGE_WORDS-1:0][15:0] page_regs;
    logic [7:0] last_ctrl;
    logic [7:0] stat;
    logic [15:0] in_word;
    logic [15:0] proc_out;
    logic unlocked;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [7:0] ctrl;
  logic [15:0] out_word;
  logic [5:0] reg_num;
  logic [15:0] page;
  logic page_ok;
  logic [2:0] page_idx;
  logic [15:0] rd_val;

  // Decode the incoming control byte and data word.
  assign ctrl = link.out_byte0;
  assign out_word = {link.out_byte1, link.out_byte2};
  assign reg_num = ctrl[REG_NUM_W-1:0];
  assign page = st_q.fixed_regs[PAGE_SELECT_OFS[4:0]];
  // Unused page numbers read as zero and swallow writes.
  assign page_ok = (page >= 16'(FIRST_PAGE)) && (page < 16'(FIRST_PAGE + NUM_PAGES));
  assign page_idx = 3'(page - 16'(FIRST_PAGE));

  // Read mux over fixed and paged halves.
  always_comb begin
    if (!reg_num[5]) begin
      rd_val = st_q.fixed_regs[reg_num[4:0]];
    end else if (page_ok) begin
      rd_val = st_q.page_regs[page_idx][reg_num[4:0]];
    end else begin
      rd_val = WORD_RST;
    end
  end

  // A write request is acted on once, when the control byte changes, so a held write
  // does not keep rewriting. Stored values act at once: a page select write switches
  // the paged half on the next cycle, and a reset clears them except the page select, which returns to four.
  always_comb begin
    st_d = st_q;
    st_d.last_ctrl = ctrl;
    if (!ctrl[CTRL_ACCESS_BIT]) begin
      st_d.proc_out = out_word;
      st_d.in_word = proc_in_word;
      st_d.stat = CTRL_RST;
    end else if (ctrl[CTRL_WRITE_BIT]) begin
      st_d.stat = ctrl & ~(8'h01 << CTRL_WRITE_BIT);
      if (ctrl != st_q.last_ctrl) begin
        if (reg_num == WRITE_UNLOCK_KEY_OFS) begin
          st_d.fixed_regs[WRITE_UNLOCK_KEY_OFS[4:0]] = out_word;
          st_d.unlocked = (out_word == UNLOCK_KEY);
        end else if (st_q.unlocked) begin
          if (!reg_num[5]) begin
            st_d.fixed_regs[reg_num[4:0]] = out_word;
          end else if (page_ok) begin
            st_d.page_regs[page_idx][reg_num[4:0]] = out_word;
          end
        end
      end
    end else begin
      st_d.stat = ctrl;
      st_d.in_word = rd_val;
    end
  end

  // State register; protection is on after reset and the page starts at four.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.fixed_regs[PAGE_SELECT_OFS[4:0]] <= PAGE_SELECT_RST;
      st_q.fixed_regs[WRITE_UNLOCK_KEY_OFS[4:0]] <= WRITE_UNLOCK_KEY_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Answer bytes, high byte first.
  assign link.in_byte0 = st_q.stat;
  assign link.in_byte1 = st_q.in_word[15:8];
  assign link.in_byte2 = st_q.in_word[7:0];
  assign proc_out_word = st_q.proc_out;
  assign unlocked = st_q.unlocked;
  assign active_page = page;
endmodule : regport_device

/* File: logic/regport_host.sv */
// Coupler end: turns single register requests into control bytes and waits for the receipt.
`timescale 1ns/1ps
module regport_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Process image link.
  regport_if.host link,
  // User request.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [5:0] req_reg,
  input wire logic [15:0] req_wdata,
  // User answer.
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_timeout
);
  import regport_pkg::*;

  typedef enum logic [1:0] {IDLE, WAIT_ACK, DONE} state_e;

  typedef struct packed {
    state_e state;
    logic [7:0] ctrl;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [7:0] timer;
    logic valid;
    logic timeout;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic [7:0] expect_stat;

  // Expected receipt for the pending request.
  assign expect_stat = st_q.ctrl[CTRL_WRITE_BIT] ?
    (st_q.ctrl & ~(8'h01 << CTRL_WRITE_BIT)) : st_q.ctrl;

  // Issue, wait for the receipt, then drop access mode for one cycle so that
  // a repeated identical request is seen as new by the terminal.
  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    case (st_q.state)
      IDLE: begin
        if (req_valid) begin
          st_d.ctrl = {1'b1, req_write, req_reg};
          // Reads pass the user's word on as well; the terminal must not act on it.
          st_d.wdata = req_wdata;
          st_d.timer = '0;
          st_d.state = WAIT_ACK;
        end
      end
      WAIT_ACK: begin
        st_d.timer = st_q.timer + 8'h01;
        if (link.in_byte0 == expect_stat) begin
          // Write answers carry no valid data.
          st_d.rdata = st_q.ctrl[CTRL_WRITE_BIT] ? WORD_RST :
            {link.in_byte1, link.in_byte2};
          st_d.valid = 1'b1;
          st_d.timeout = 1'b0;
          st_d.state = DONE;
        end else if (st_q.timer == HOST_TIMEOUT_CYC) begin
          st_d.valid = 1'b1;
          st_d.timeout = 1'b1;
          st_d.state = DONE;
        end
      end
      DONE: begin
        st_d.ctrl = CTRL_RST;
        st_d.state = IDLE;
      end
      default: begin
        st_d.state = IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs; the user must write the page select before paged accesses.
  assign req_ready = (st_q.state == IDLE);
  assign link.out_byte0 = st_q.ctrl;
  assign link.out_byte1 = st_q.wdata[15:8];
  assign link.out_byte2 = st_q.wdata[7:0];
  assign rsp_valid = st_q.valid;
  assign rsp_rdata = st_q.rdata;
  assign rsp_timeout = st_q.timeout;
endmodule : regport_host

/* File: test/regport_sva.sv */
// Checker for the process image bytes exchanged between host and terminal.
`timescale 1ns/1ps
module regport_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Process image bytes.
  input wire logic [7:0] out_byte0,
  input wire logic [7:0] out_byte1,
  input wire logic [7:0] out_byte2,
  input wire logic [7:0] in_byte0,
  input wire logic [7:0] in_byte1,
  input wire logic [7:0] in_byte2
);
  import regport_pkg::*;
  logic [15:0] key_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Mirror of the unlock key; that register is writable even when locked.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) key_q <= WRITE_UNLOCK_KEY_RST;
    else if (out_byte0 == 8'hDF) key_q <= {out_byte1, out_byte2};
  end
  AST_READ_ECHO: assert property (out_byte0[7:6] == 2'b10 |=> in_byte0 == $past(out_byte0))
    else $error("Read receipt differs from control byte");
  AST_WRITE_ECHO: assert property (out_byte0[7:6] == 2'b11 |=> in_byte0 == {2'b10, $past(out_byte0[5:0])})
    else $error("Write receipt does not clear the direction bit");
  AST_KEY_READBACK: assert property (out_byte0 == 8'h9F && $past(out_byte0) == 8'h9F |-> {in_byte1, in_byte2} == key_q)
    else $error("Key register read returns a wrong word");
  AST_ACCESS_BIT: assert property (out_byte0 != 8'h00 |-> out_byte0[7])
    else $error("Request without the access bit");
  AST_HOLD: assert property ($rose(out_byte0[7]) |=> $stable(out_byte0) && $stable({out_byte1, out_byte2}))
    else $error("Request dropped before its receipt");
  AST_BOUNDED: assert property ($rose(out_byte0[7]) |-> ##[1:260] !out_byte0[7])
    else $error("Request never released");
  AST_GAP: assert property ($fell(out_byte0[7]) |-> out_byte0 == 8'h00)
    else $error("No idle control byte between requests");
  AST_STATUS_STEADY: assert property (out_byte0[7] && $stable(out_byte0) |=> $stable(in_byte0))
    else $error("Receipt changed while request held");
  // Main scenarios: reads, writes and the unlock key.
  cover property (out_byte0[7:6] == 2'b10);
  cover property (out_byte0[7:6] == 2'b11);
  cover property (out_byte0 == 8'hDF && {out_byte1, out_byte2} == UNLOCK_KEY);
endmodule : regport_sva

/* File: test/paged_register_access_port_tb.sv */
// Self-checking bench joining host and terminal ends through the process image.
`timescale 1ns/1ps
module paged_register_access_port_tb;
  import regport_pkg::*;
  logic clk, resetn, req_valid, req_ready, req_write, rsp_valid, rsp_timeout, unlocked;
  logic [5:0] req_reg;
  logic [15:0] req_wdata, rsp_rdata, proc_in_word, proc_out_word, active_page;
  int err_total = 0;
  int samples_checked = 0;
  regport_if link_if ();
  regport_device regport_device_i (.clk(clk), .resetn(resetn), .link(link_if),
    .proc_out_word(proc_out_word), .proc_in_word(proc_in_word), .unlocked(unlocked),
    .active_page(active_page));
  regport_host regport_host_i (.clk(clk), .resetn(resetn), .link(link_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_reg(req_reg),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_timeout(rsp_timeout));
  regport_sva regport_sva_i (.clk(clk), .resetn(resetn), .out_byte0(link_if.out_byte0),
    .out_byte1(link_if.out_byte1), .out_byte2(link_if.out_byte2),
    .in_byte0(link_if.in_byte0), .in_byte1(link_if.in_byte1), .in_byte2(link_if.in_byte2));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One request through the host; reads compare the returned word. Handshake
  // outputs are looked at on the falling edge, where they have settled, so the
  // one-cycle response pulse cannot be missed in a race with the clock edge.
  task automatic access(input logic wr, input logic [5:0] num, input logic [15:0] wd,
                        input logic [15:0] exp);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_reg <= num;
    req_wdata <= wd;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) err_total++;
    if (!wr) check(rsp_rdata, exp);
    else check(rsp_rdata, WORD_RST);
    check({15'h0000, rsp_timeout}, 16'h0000);
    @(posedge clk);
  endtask : access
  task automatic results();
    $display("Checked %0d values, %0d errors", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The whole run is a few hundred cycles, so this limit only trips on a hang.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_reg = 6'h00;
    req_wdata = 16'h0000;
    proc_in_word = 16'h5AC3;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    check(active_page, PAGE_SELECT_RST);
    repeat (3) @(posedge clk);
    check({link_if.in_byte1, link_if.in_byte2}, 16'h5AC3);
    access(1'b1, 6'h04, 16'h0005, 16'h0000);
    check(active_page, 16'h0004);
    access(1'b1, 6'h1F, UNLOCK_KEY, 16'h0000);
    check({15'h0000, unlocked}, 16'h0001);
    access(1'b0, 6'h1F, 16'h0000, UNLOCK_KEY);
    // Fill register 63 (word 31) of every page, then read each back to prove the pages are apart.
    for (int p = 4; p <= 9; p++) begin
      access(1'b1, 6'h04, 16'(p), 16'h0000);
      access(1'b1, 6'h3F, 16'h1100 + 16'(p), 16'h0000);
    end
    for (int p = 4; p <= 9; p++) begin
      access(1'b1, 6'h04, 16'(p), 16'h0000);
      access(1'b0, 6'h3F, 16'h0000, 16'h1100 + 16'(p));
    end
    access(1'b0, 6'h3F, 16'hFFFF, 16'h1109);
    repeat (2) @(posedge clk);
    check(proc_out_word, 16'hFFFF);
    access(1'b0, 6'h3F, 16'h0000, 16'h1109);
    access(1'b0, 6'h20, 16'h0000, 16'h0000);
    access(1'b1, 6'h04, 16'h0003, 16'h0000);
    access(1'b0, 6'h3F, 16'h0000, 16'h0000);
    access(1'b1, 6'h1F, 16'h0000, 16'h0000);
    check({15'h0000, unlocked}, 16'h0000);
    access(1'b1, 6'h04, 16'h0005, 16'h0000);
    access(1'b0, 6'h04, 16'h0000, 16'h0003);
    // A second reset in mid-run must restore protection, the first page and empty pages.
    resetn <= 1'b0;
    @(posedge clk);
    check(active_page, PAGE_SELECT_RST);
    check({15'h0000, unlocked}, 16'h0000);
    resetn <= 1'b1;
    access(1'b0, 6'h3F, 16'h0000, WORD_RST);
    results();
  end
endmodule : paged_register_access_port_tb
